// ===== logic/crc_ctl_pkg.sv
// What this block does
// - the engine runs only while engine_on, bit 15 of the control register, is one.
// - clearing engine_on resets engine state, fifo pointers and data words, not other registers.
// - with halt_in_idle set the engine pauses while the host is idle, else it runs on.
// - a read-only five-bit field gives the fifo word count, at most 8 or 16 by data length.
// - fifo_full_flag, bit 7, is one exactly while the fifo holds its maximum words.
// - fifo_empty_flag, bit 6, is one while the fifo is empty and reads one after reset.
// - with irq_source_select one the interrupt is raised when the fifo goes empty.
// - with irq_source_select zero the interrupt is raised when shifting is done.
// - writing one to shifter_start runs the shifter on the fifo, zero stops it.
package crc_ctl_pkg;
  localparam logic [11:0] addr_control   = 12'h000;
  localparam logic [11:0] addr_length    = 12'h004;
  localparam logic [11:0] addr_data_in   = 12'h008;
  localparam logic [11:0] addr_result    = 12'h00c;
  localparam logic [11:0] addr_irq_stat  = 12'h010;
  localparam logic [11:0] addr_irq_en    = 12'h014;
  localparam logic [11:0] addr_irq_clr   = 12'h018;
  localparam int bit_engine_on    = 15;
  localparam int bit_halt_in_idle = 13;
  localparam int count_lsb        = 8;
  localparam int bit_full         = 7;
  localparam int bit_empty        = 6;
  localparam int bit_irq_sel      = 5;
  localparam int bit_start        = 4;
  localparam int bit_lsb_first    = 3;
  localparam logic [15:0] control_write_mask = 16'ha038;
  localparam logic [4:0]  depth_long  = 5'h10;
  localparam logic [4:0]  depth_short = 5'h08;
  localparam logic [4:0]  length_split = 5'h07;
  localparam logic [4:0]  word_bits_max = 5'h1f;
  localparam int irq_bits = 2;
  localparam int irq_empty = 0;
  localparam int irq_done  = 1;
  typedef enum logic [1:0] {
    sh_idle  = 2'b00,
    sh_load  = 2'b01,
    sh_shift = 2'b10
  } shift_state_type;
endpackage

// ===== logic/crc_word_fifo.sv
`timescale 1ns/1ps
module crc_word_fifo #(
  parameter int width = 32,
  parameter int depth = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic [4:0]       limit,
  input  wire logic             push,
  input  wire logic [width-1:0] push_data,
  input  wire logic             pop,
  output logic      [width-1:0] pop_data,
  output logic      [4:0]       count
);
  logic [width-1:0] mem [depth];
  logic [3:0]       rd_ptr;
  logic [3:0]       wr_ptr;
  logic [3:0]       next_rd_ptr;
  logic [3:0]       next_wr_ptr;
  logic [4:0]       next_count;
  logic             do_push;
  logic             do_pop;

  always_comb begin
    do_push     = push && (count < limit);
    do_pop      = pop && (count != 5'h00);
    next_rd_ptr = do_pop ? rd_ptr + 4'h1 : rd_ptr;
    next_wr_ptr = do_push ? wr_ptr + 4'h1 : wr_ptr;
    next_count  = count + {4'h0, do_push} - {4'h0, do_pop};
    if (flush) begin
      next_rd_ptr = 4'h0;
      next_wr_ptr = 4'h0;
      next_count  = 5'h00;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      count  <= 5'h00;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_push && !flush) begin
      mem[wr_ptr] <= push_data;
    end
  end

  assign pop_data = mem[rd_ptr];
endmodule

// ===== logic/crc_shift_core.sv
`timescale 1ns/1ps
module crc_shift_core (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        flush,
  input  wire logic        run,
  input  wire logic [31:0] poly,
  input  wire logic [4:0]  word_bits,
  input  wire logic [31:0] word,
  input  wire logic        lsb_first,
  input  wire logic        bit_step,
  input  wire logic        bit_last,
  output logic      [31:0] result
);
  import crc_ctl_pkg::*;
  logic [31:0] next_result;
  logic        in_bit;
  logic        fb;
  logic [31:0] top_mask;

  always_comb begin
    in_bit      = lsb_first ? word[0] : word[word_bits];
    top_mask    = 32'h1 << word_bits;
    fb          = in_bit ^ ((result & top_mask) != 32'h0);
    next_result = result;
    if (run && bit_step) begin
      next_result = (result << 1) ^ (fb ? poly : 32'h0);
    end
    if (flush) begin
      next_result = 32'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result <= 32'h0;
    end else begin
      result <= next_result;
    end
  end
endmodule

// ===== logic/crc_engine_control.sv
`timescale 1ns/1ps
module crc_engine_control (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        host_idle,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  import crc_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0]      control;
  logic [15:0]      next_control;
  logic [4:0]       data_length_setting;
  logic [4:0]       next_length;
  logic [31:0]      poly;
  logic [31:0]      next_poly;
  logic [irq_bits-1:0] irq_status;
  logic [irq_bits-1:0] next_irq_status;
  logic [irq_bits-1:0] irq_enable;
  logic [irq_bits-1:0] next_irq_enable;
  logic [31:0]      next_prdata;
  logic             read_setup;
  logic             next_irq;
  logic             idle_sync_a;
  logic             idle_sync_b;
  logic             empty_prev;
  logic             next_empty_prev;

  logic             access;
  logic             wr;
  logic             engine_on;
  logic             running;
  logic             start;
  logic             shifter_start_clr;
  logic             push;
  logic             pop;
  logic [31:0]      checksum_input_word;
  logic [31:0]      checksum_result_word;
  logic [4:0]       fifo_word_count;
  logic [4:0]       fifo_limit;
  logic             fifo_full_flag;
  logic             fifo_empty_flag;
  logic             flush;
  logic             done_pulse;
  logic [31:0]      crc_fifo_out;

  ////////////////////////////////////////////////////////////////////////////
  // shifter state
  shift_state_type  state;
  shift_state_type  next_state;
  logic [31:0]      word;
  logic [31:0]      next_word;
  logic [4:0]       bit_cnt;
  logic [4:0]       next_bit_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic write_hit(input logic        wr_now,
                                     input logic [11:0] addr,
                                     input logic [11:0] target);
    return wr_now && addr == target;
  endfunction

  // byte lane merge for the polynomial word
  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign access    = psel && penable;
  assign wr        = access && pwrite;
  assign pready    = 1'b1;
  assign engine_on = control[bit_engine_on];
  assign flush     = !engine_on;
  assign running   = engine_on &&
                     !(control[bit_halt_in_idle] && idle_sync_b);
  assign start     = control[bit_start];
  // data words are dropped while off or at the limit
  assign push      = write_hit(wr, paddr, addr_data_in) && engine_on;
  assign checksum_input_word = pwdata;

  // depth limit chosen by data length
  assign fifo_limit = (data_length_setting > length_split) ?
                      depth_short : depth_long;
  assign fifo_full_flag  = fifo_word_count == fifo_limit;
  assign fifo_empty_flag = fifo_word_count == 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // host idle synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_sync_a <= 1'b0;
      idle_sync_b <= 1'b0;
    end else begin
      idle_sync_a <= host_idle;
      idle_sync_b <= idle_sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial shifter sequence
  always_comb begin
    next_state   = state;
    next_word    = word;
    next_bit_cnt = bit_cnt;
    pop          = 1'b0;
    done_pulse   = 1'b0;
    shifter_start_clr = 1'b0;
    case (state)
      sh_idle: begin
        if (running && start && !fifo_empty_flag) begin
          next_state = sh_load;
        end
      end
      sh_load: begin
        if (!start) begin
          next_state = sh_idle;
        end else if (running) begin
          next_word    = crc_fifo_out;
          next_bit_cnt = data_length_setting;
          pop          = 1'b1;
          next_state   = sh_shift;
        end
      end
      sh_shift: begin
        if (!start) begin
          next_state = sh_idle;
        end else if (running) begin
          next_word = control[bit_lsb_first] ? word >> 1 :
                      word << 1;
          next_bit_cnt = bit_cnt - 5'h01;
          if (bit_cnt == 5'h00) begin
            if (fifo_empty_flag) begin
              next_state        = sh_idle;
              done_pulse        = 1'b1;
              shifter_start_clr = 1'b1;
            end else begin
              next_state = sh_load;
            end
          end
        end
      end
      default: next_state = sh_idle;
    endcase
    if (flush) begin
      next_state   = sh_idle;
      next_word    = 32'h0;
      next_bit_cnt = 5'h00;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state   <= sh_idle;
      word    <= 32'h0;
      bit_cnt <= 5'h00;
    end else begin
      state   <= next_state;
      word    <= next_word;
      bit_cnt <= next_bit_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word fifo and serial core
  // pointers, count and result clear while engine_on is low
  crc_word_fifo #(
    .width (32),
    .depth (16)
  ) i_crc_word_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (flush),
    .limit     (fifo_limit),
    .push      (push),
    .push_data (checksum_input_word),
    .pop       (pop),
    .pop_data  (crc_fifo_out),
    .count     (fifo_word_count)
  );

  crc_shift_core i_crc_shift_core (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (flush),
    .run       (running),
    .poly      (poly),
    .word_bits (data_length_setting),
    .word      (word),
    .lsb_first (control[bit_lsb_first]),
    .bit_step  (state == sh_shift && start),
    .bit_last  (bit_cnt == 5'h00),
    .result    (checksum_result_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes and interrupt status
  always_comb begin
    next_control    = control;
    next_length     = data_length_setting;
    next_poly       = poly;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_empty_prev = fifo_empty_flag;
    if (write_hit(wr, paddr, addr_control)) begin
      next_control = pwdata[15:0] & control_write_mask;
    end else if (shifter_start_clr) begin
      // a software write in the same cycle wins over the self-clear
      next_control[bit_start] = 1'b0;
    end
    if (write_hit(wr, paddr, addr_length)) begin
      next_length = pwdata[4:0];
      next_poly   = byte_merge(poly, pwdata, pstrb) & 32'hffff_ffe0 |
                    32'h0;
    end
    if (write_hit(wr, paddr, addr_irq_en)) begin
      next_irq_enable = pwdata[irq_bits-1:0];
    end
    if (write_hit(wr, paddr, addr_irq_clr)) begin
      next_irq_status = irq_status & ~pwdata[irq_bits-1:0];
    end
    // set wins over clear
    if (control[bit_irq_sel] && fifo_empty_flag && !empty_prev &&
        engine_on) begin
      next_irq_status[irq_empty] = 1'b1;
    end
    if (!control[bit_irq_sel] && done_pulse) begin
      next_irq_status[irq_done] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control             <= 16'h0000;
      data_length_setting <= 5'h00;
      poly                <= 32'h0;
      irq_enable          <= '0;
      irq_status          <= '0;
      empty_prev          <= 1'b1;
      irq                 <= 1'b0;
    end else begin
      control             <= next_control;
      data_length_setting <= next_length;
      poly                <= next_poly;
      irq_enable          <= next_irq_enable;
      irq_status          <= next_irq_status;
      empty_prev          <= next_empty_prev;
      irq                 <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle so it stands through access
  always_comb begin
    read_setup  = psel && !penable;
    next_prdata = 32'h0;
    pslverr     = 1'b0;
    case (paddr)
      addr_control: begin
        next_prdata[15:0] = control & control_write_mask;
        next_prdata[count_lsb +: 5] = fifo_word_count;
        next_prdata[bit_full]  = fifo_full_flag;
        next_prdata[bit_empty] = fifo_empty_flag;
      end
      addr_length:   next_prdata = poly | {27'h0, data_length_setting};
      addr_data_in:  next_prdata = 32'h0;
      addr_result:   next_prdata = checksum_result_word;
      addr_irq_stat: next_prdata[irq_bits-1:0] = irq_status;
      addr_irq_en:   next_prdata[irq_bits-1:0] = irq_enable;
      addr_irq_clr:  next_prdata = 32'h0;
      default:       pslverr = access;
    endcase
    if (!read_setup) begin
      // hold the word captured in setup
      next_prdata = prdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else begin
      prdata <= next_prdata;
    end
  end
endmodule

// ===== verif/crc_engine_control_sva.sv
`timescale 1ns/1ps
module crc_engine_control_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        host_idle,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  import crc_ctl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic        acc;
  logic [15:0] ctl_seen;
  logic [15:0] next_ctl_seen;
  logic [1:0]  en_seen;
  logic [1:0]  next_en_seen;
  assign acc = psel && penable;
  // last written control and irq enable values
  always_comb begin
    next_ctl_seen = ctl_seen;
    next_en_seen = en_seen;
    if (acc && pwrite && paddr == addr_control) begin
      next_ctl_seen = pwdata[15:0] & 16'ha028;
    end
    if (acc && pwrite && paddr == addr_irq_en) begin
      next_en_seen = pwdata[1:0];
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_seen <= 16'h0000;
      en_seen <= 2'h0;
    end else begin
      ctl_seen <= next_ctl_seen;
      en_seen <= next_en_seen;
    end
  end
  sequence ctl_rd;
    acc && !pwrite && paddr == addr_control;
  endsequence
  AST_READY: assert property (acc |-> pready)
    else $error("no ready in access phase");
  AST_UNMAPPED: assert property (acc && paddr > addr_irq_clr |-> pslverr)
    else $error("unmapped access not refused");
  AST_CTRL_BITS: assert property (ctl_rd |->
    (prdata & 32'hffff_e02f) == {16'h0000, ctl_seen})
    else $error("control readback wrong");
  AST_EMPTY: assert property (ctl_rd |-> prdata[6] == (prdata[12:8] == 5'h00))
    else $error("empty flag wrong");
  AST_COUNT_MAX: assert property (ctl_rd |-> prdata[12:8] <= depth_long)
    else $error("word count too large");
  AST_FULL: assert property (ctl_rd ##0 prdata[7] |->
    prdata[12:8] == depth_short || prdata[12:8] == depth_long)
    else $error("full flag wrong");
  AST_OFF_FLUSH: assert property (ctl_rd ##0 !ctl_seen[15] |->
    prdata[12:8] == 5'h00)
    else $error("fifo not flushed while off");
  AST_IRQ_MASKED: assert property (en_seen == 2'h0 && $past(en_seen) == 2'h0
    |-> !irq)
    else $error("irq while masked");
endmodule
bind crc_engine_control crc_engine_control_sva i_crc_engine_control_sva (
  .ref_clk(ref_clk), .rst(rst), .host_idle(host_idle), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));

// ===== verif/crc_engine_control_bench.sv
`timescale 1ns/1ps
module crc_engine_control_bench;
  import crc_ctl_pkg::*;
  logic        ref_clk, rst, host_idle, psel, penable, pwrite, slv;
  logic        pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r1, r2, r3;
  logic [3:0]  pstrb;
  int          err_count, cmp_count, i;
  crc_engine_control i_crc_engine_control (.ref_clk(ref_clk), .rst(rst),
    .host_idle(host_idle), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task print_verdict();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, read data and error taken at the ready edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 16) begin
      err_count++;
      print_verdict();
    end
  endtask
  task wait_irq();
    int n;
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge ref_clk);
    if (irq !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask
  task one_word(input logic [31:0] c, input logic [31:0] w,
                output logic [31:0] r);
    bus(1, addr_control, 32'h0);
    bus(1, addr_control, c);
    bus(1, addr_irq_clr, 32'h3);
    bus(1, addr_irq_en, 32'h2);
    bus(1, addr_data_in, w);
    check({31'h0, irq}, 32'h0);
    bus(1, addr_control, c | 32'h10);
    wait_irq();
    bus(0, addr_result, 32'h0);
    r = rd;
  endtask
  initial begin
    rst = 1'b1;
    host_idle = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    err_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus(0, addr_control, 32'h0);
    check(rd, 32'h0000_0040);
    bus(1, addr_control, 32'hffff_ffef);
    bus(0, addr_control, 32'h0);
    check(rd, 32'h0000_a068);
    bus(1, addr_length, 32'h0000_0e07);
    for (i = 0; i < 17; i++) bus(1, addr_data_in, i);
    bus(0, addr_control, 32'h0);
    check(rd, 32'h0000_b0a8);
    host_idle <= 1'b1;
    bus(1, addr_irq_en, 32'h1);
    bus(1, addr_control, 32'h0000_a038);
    repeat (60) @(posedge ref_clk);
    bus(0, addr_control, 32'h0);
    check(rd, 32'h0000_b0b8);
    check({31'h0, irq}, 32'h0);
    host_idle <= 1'b0;
    wait_irq();
    bus(0, addr_control, 32'h0);
    check(rd & 32'h1fc0, 32'h0040);
    bus(0, addr_irq_stat, 32'h0);
    check(rd & 32'h1, 32'h1);
    bus(1, addr_irq_en, 32'h0);
    check({31'h0, irq}, 32'h0);
    one_word(32'h8008, 32'h01, r1);
    bus(0, addr_control, 32'h0);
    check(rd & 32'h10, 32'h0);
    one_word(32'h8000, 32'h80, r2);
    one_word(32'h8000, 32'h01, r3);
    check({31'h0, r1 === r2}, 32'h1);
    check({31'h0, r1 !== r3}, 32'h1);
    bus(1, addr_control, 32'h0);
    bus(0, addr_result, 32'h0);
    check(rd, 32'h0);
    bus(0, addr_length, 32'h0);
    check(rd, 32'h0000_0e07);
    bus(1, addr_length, 32'h0000_0e08);
    bus(1, addr_control, 32'h8000);
    for (i = 0; i < 9; i++) bus(1, addr_data_in, i);
    bus(0, addr_control, 32'h0);
    check(rd, 32'h0000_8880);
    bus(1, addr_control, 32'h0);
    bus(0, addr_control, 32'h0);
    check(rd, 32'h0000_0040);
    bus(0, 12'h01c, 32'h0);
    check({31'h0, slv}, 32'h1);
    check(rd, 32'h0);
    print_verdict();
  end
endmodule
